// ---- rtl/nvsw_ctrl.sv ----
// nvm self-write controller: apb registers, unlock, buffered flash block and eeprom write
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "nvsw_defs.svh"

module nvsw_ctrl #(
   parameter int unsigned PWRT_CYCLES = `NVSW_PWRT_CYCLES,
   parameter int unsigned ERASE_CYCLES = `NVSW_ERASE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic power_on_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // configuration fuse and external programming port
   input wire logic data_lock_fuse_i,
   input wire logic ext_prog_req_i,
   output logic ext_prog_grant_o,
   // nonvolatile array
   output logic mem_wr_o,
   output logic mem_rd_o,
   output logic mem_space_o,
   output logic mem_erase_o,
   output logic [12:0] mem_addr_o,
   output logic [13:0] mem_wdata_o,
   input wire logic [13:0] mem_rdata_i,
   // processor side
   output logic cpu_stall_o,
   output logic irq_o
);
   nvsw_pkg::nvsw_state_t state_q;
   nvsw_pkg::nvsw_key_t key_q;
   logic [7:0] addr_lo_q;
   logic [7:0] addr_hi_q;
   logic [7:0] data_lo_q;
   logic [7:0] data_hi_q;
   logic space_q;
   logic permit_q;
   logic go_q;
   logic fault_q;
   logic done_q;
   logic done_en_q;
   logic gie_q;
   logic [31:0] pwrt_cnt_q;
   logic [31:0] op_cnt_q;
   logic [13:0] buf_q [0:7];
   logic [12:0] op_addr_q;
   logic wr_acc;
   logic rd_acc;
   logic go_req;
   logic launch;
   logic pwrt_busy;
   logic op_done;
   logic busy;

   assign wr_acc = psel_i && penable_i && pwrite_i;
   // array read request: read bit written while no write is running
   assign rd_acc = wr_acc && (paddr_i == `NVSW_OFF_CONTROL) && pwdata_i[`NVSW_BIT_READ] && !busy;
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;
   assign pwrt_busy = (pwrt_cnt_q != 32'h0);
   assign busy = (state_q != nvsw_pkg::NVSW_IDLE);
   assign go_req = wr_acc && (paddr_i == `NVSW_OFF_CONTROL) && pwdata_i[`NVSW_BIT_GO];
   // go takes effect only after the key sequence and with the permit bit set
   assign launch = go_req && !busy && permit_q && (key_q == nvsw_pkg::NVSW_KEY_OPEN)
      && !(pwrt_busy && !pwdata_i[`NVSW_BIT_SPACE]);
   assign op_done = (op_cnt_q == 32'h0);
   assign irq_o = gie_q && done_en_q && done_q;
   // external programming reaches data eeprom only when the fuse is unprogrammed
   assign ext_prog_grant_o = ext_prog_req_i && data_lock_fuse_i;

   // power-up timer
   always_ff @(posedge sys_clk_i)
   begin
      if (power_on_i)
         pwrt_cnt_q <= PWRT_CYCLES;
      else if (pwrt_busy)
         pwrt_cnt_q <= pwrt_cnt_q - 32'h1;
   end

   // unlock key tracker: any other write or go consumes it
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         key_q <= nvsw_pkg::NVSW_KEY_NONE;
      else if (wr_acc && paddr_i == `NVSW_OFF_UNLOCK)
      begin
         if (pwdata_i[7:0] == `NVSW_KEY_FIRST)
            key_q <= nvsw_pkg::NVSW_KEY_HALF;
         else if (pwdata_i[7:0] == `NVSW_KEY_SECOND && key_q == nvsw_pkg::NVSW_KEY_HALF)
            key_q <= nvsw_pkg::NVSW_KEY_OPEN;
         else
            key_q <= nvsw_pkg::NVSW_KEY_NONE;
      end
      else if (wr_acc)
         key_q <= nvsw_pkg::NVSW_KEY_NONE;
   end

   // address, data and read results
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         addr_lo_q <= 8'h00;
         addr_hi_q <= 8'h00;
         data_lo_q <= 8'h00;
         data_hi_q <= 8'h00;
      end
      else if (mem_rd_o)
      begin
         data_lo_q <= mem_rdata_i[7:0];
         data_hi_q <= space_q ? {2'b00, mem_rdata_i[13:8]} : 8'h00;
      end
      else if (wr_acc)
      begin
         case (paddr_i)
            `NVSW_OFF_ADDR_LO: addr_lo_q <= pwdata_i[7:0];
            `NVSW_OFF_ADDR_HI: addr_hi_q <= pwdata_i[7:0] & `NVSW_ADDR_HI_MASK;
            `NVSW_OFF_DATA_LO: data_lo_q <= pwdata_i[7:0];
            `NVSW_OFF_DATA_HI: data_hi_q <= pwdata_i[7:0] & `NVSW_DATA_HI_MASK;
            default: ;
         endcase
      end
   end

   // control bits; permit cleared at every power-up
   always_ff @(posedge sys_clk_i)
   begin
      if (power_on_i)
      begin
         permit_q <= 1'b0;
         space_q <= 1'b0;
      end
      else if (wr_acc && paddr_i == `NVSW_OFF_CONTROL)
      begin
         permit_q <= pwdata_i[`NVSW_BIT_PERMIT];
         space_q <= busy ? space_q : pwdata_i[`NVSW_BIT_SPACE];
      end
   end

   // fault flag: a reset arriving mid-write marks the write incomplete
   always_ff @(posedge sys_clk_i)
   begin
      if (power_on_i)
         fault_q <= 1'b0;
      else if (reset_i && busy)
         fault_q <= 1'b1;
      else if (wr_acc && paddr_i == `NVSW_OFF_CONTROL && !pwdata_i[`NVSW_BIT_FAULT])
         fault_q <= 1'b0;
   end

   // read strobe pulse
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         mem_rd_o <= 1'b0;
      else
         mem_rd_o <= rd_acc;
   end

   // write sequencer
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_q <= nvsw_pkg::NVSW_IDLE;
         go_q <= 1'b0;
         op_cnt_q <= 32'h0;
         op_addr_q <= 13'h0;
         mem_wr_o <= 1'b0;
         mem_erase_o <= 1'b0;
         mem_space_o <= 1'b0;
         mem_addr_o <= 13'h0;
         mem_wdata_o <= 14'h0;
         cpu_stall_o <= 1'b0;
      end
      else
      begin
         mem_wr_o <= 1'b0;
         case (state_q)
            nvsw_pkg::NVSW_IDLE:
            begin
               if (launch)
               begin
                  go_q <= 1'b1;
                  op_addr_q <= {addr_hi_q[4:0], addr_lo_q};
                  // flash words first go through the buffer slot; the space bit
                  // written with go is the one the control register keeps
                  if (pwdata_i[`NVSW_BIT_SPACE])
                  begin
                     state_q <= nvsw_pkg::NVSW_BUFFER;
                     op_cnt_q <= `NVSW_BUF_SLOT_CYCLES;
                  end
                  else
                  begin
                     state_q <= nvsw_pkg::NVSW_EE_WRITE;
                     op_cnt_q <= `NVSW_EE_WRITE_CYCLES;
                  end
                  cpu_stall_o <= pwdata_i[`NVSW_BIT_SPACE];
               end
               else if (rd_acc)
               begin
                  // present the array address for the read strobe that follows
                  mem_space_o <= pwdata_i[`NVSW_BIT_SPACE];
                  mem_addr_o <= {addr_hi_q[4:0], addr_lo_q};
               end
            end
            nvsw_pkg::NVSW_BUFFER:
            begin
               buf_q[op_addr_q[2:0]] <= {data_hi_q[5:0], data_lo_q};
               if (op_addr_q[2:0] == 3'b111)
               begin
                  state_q <= nvsw_pkg::NVSW_FLASH_ERASE;
                  op_cnt_q <= ERASE_CYCLES;
                  mem_erase_o <= 1'b1;
                  mem_space_o <= 1'b1;
                  mem_addr_o <= {op_addr_q[12:3], 3'b000};
               end
               else
                  state_q <= nvsw_pkg::NVSW_FINISH;
            end
            nvsw_pkg::NVSW_EE_WRITE:
            begin
               if (op_done)
               begin
                  mem_wr_o <= 1'b1;
                  mem_space_o <= 1'b0;
                  mem_addr_o <= op_addr_q;
                  mem_wdata_o <= {6'h00, data_lo_q};
                  state_q <= nvsw_pkg::NVSW_FINISH;
               end
               else
                  op_cnt_q <= op_cnt_q - 32'h1;
            end
            nvsw_pkg::NVSW_FLASH_ERASE:
            begin
               // processor halted while the block is erased and written
               if (op_done)
               begin
                  mem_erase_o <= 1'b0;
                  state_q <= nvsw_pkg::NVSW_FINISH;
               end
               else
               begin
                  op_cnt_q <= op_cnt_q - 32'h1;
                  if (op_cnt_q <= 32'h8)
                  begin
                     mem_wr_o <= 1'b1;
                     mem_addr_o <= {op_addr_q[12:3], 3'(8 - op_cnt_q)};
                     mem_wdata_o <= buf_q[3'(8 - op_cnt_q)];
                  end
               end
            end
            nvsw_pkg::NVSW_FINISH:
            begin
               go_q <= 1'b0;
               cpu_stall_o <= 1'b0;
               state_q <= nvsw_pkg::NVSW_IDLE;
            end
            default: state_q <= nvsw_pkg::NVSW_IDLE;
         endcase
      end
   end

   // interrupt registers; completion wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         done_q <= 1'b0;
         done_en_q <= 1'b0;
         gie_q <= 1'b0;
      end
      else
      begin
         if (state_q == nvsw_pkg::NVSW_FINISH)
            done_q <= 1'b1;
         else if (wr_acc && paddr_i == `NVSW_OFF_IRQ_CLEAR && pwdata_i[`NVSW_BIT_DONE])
            done_q <= 1'b0;
         if (wr_acc && paddr_i == `NVSW_OFF_IRQ_EN)
            done_en_q <= pwdata_i[`NVSW_BIT_DONE];
         if (wr_acc && paddr_i == `NVSW_OFF_CORE_IRQ)
            gie_q <= pwdata_i[`NVSW_BIT_GIE];
      end
   end

   // read data mux
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         prdata_o <= 32'h0;
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         case (paddr_i)
            `NVSW_OFF_CONTROL: prdata_o <= {24'h0, space_q, 3'b000, fault_q, permit_q, go_q, 1'b0};
            `NVSW_OFF_ADDR_LO: prdata_o <= {24'h0, addr_lo_q};
            `NVSW_OFF_ADDR_HI: prdata_o <= {24'h0, addr_hi_q};
            `NVSW_OFF_DATA_LO: prdata_o <= {24'h0, data_lo_q};
            `NVSW_OFF_DATA_HI: prdata_o <= {24'h0, data_hi_q};
            `NVSW_OFF_CORE_IRQ: prdata_o <= {24'h0, gie_q, 7'h00};
            `NVSW_OFF_IRQ_EN: prdata_o <= {27'h0, done_en_q, 4'h0};
            `NVSW_OFF_IRQ_FLAGS: prdata_o <= {27'h0, done_q, 4'h0};
            default: prdata_o <= 32'h0;
         endcase
      end
   end
endmodule

// ---- include/nvsw_defs.svh ----
// register offsets, field positions, key values, masks and timing counts for the nvm controller
`ifndef NVSW_DEFS_SVH
`define NVSW_DEFS_SVH
`define NVSW_OFF_CONTROL 12'h000
`define NVSW_OFF_UNLOCK 12'h004
`define NVSW_OFF_ADDR_LO 12'h008
`define NVSW_OFF_ADDR_HI 12'h00c
`define NVSW_OFF_DATA_LO 12'h010
`define NVSW_OFF_DATA_HI 12'h014
`define NVSW_OFF_CORE_IRQ 12'h018
`define NVSW_OFF_IRQ_EN 12'h01c
`define NVSW_OFF_IRQ_FLAGS 12'h020
`define NVSW_OFF_IRQ_CLEAR 12'h024
`define NVSW_BIT_READ 0
`define NVSW_BIT_GO 1
`define NVSW_BIT_PERMIT 2
`define NVSW_BIT_FAULT 3
`define NVSW_BIT_SPACE 7
`define NVSW_BIT_DONE 4
`define NVSW_BIT_GIE 7
`define NVSW_KEY_FIRST 8'h55
`define NVSW_KEY_SECOND 8'haa
`define NVSW_ADDR_HI_MASK 8'h1f
`define NVSW_DATA_HI_MASK 8'h3f
`define NVSW_CLK_HZ 10000000
`define NVSW_PWRT_MS 64
`define NVSW_PWRT_CYCLES ((`NVSW_CLK_HZ / 1000) * `NVSW_PWRT_MS)
`define NVSW_ERASE_MS 4
`define NVSW_ERASE_CYCLES ((`NVSW_CLK_HZ / 1000) * `NVSW_ERASE_MS)
`define NVSW_EE_WRITE_CYCLES 50
`define NVSW_BUF_SLOT_CYCLES 1
`endif

// ---- include/nvsw_pkg.sv ----
// types of the nvm self-write controller
package nvsw_pkg;
   typedef enum logic [2:0] {
      NVSW_IDLE = 3'b000,
      NVSW_BUFFER = 3'b001,
      NVSW_EE_WRITE = 3'b011,
      NVSW_FLASH_ERASE = 3'b010,
      NVSW_FINISH = 3'b110
   } nvsw_state_t;
   typedef enum logic [1:0] {
      NVSW_KEY_NONE = 2'b00,
      NVSW_KEY_HALF = 2'b01,
      NVSW_KEY_OPEN = 2'b11
   } nvsw_key_t;
endpackage

// ---- testbench/nvsw_ctrl_asserts.sv ----
// assertion checker bound to the nvm self-write controller
`timescale 1ns/1ns
`include "nvsw_defs.svh"
module nvsw_ctrl_asserts #(
   parameter int unsigned PWRT_CYCLES = 20
) (
   // clock, reset and apb
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic power_on_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   // fuse, array and processor side
   input wire logic data_lock_fuse_i,
   input wire logic ext_prog_req_i,
   input wire logic ext_prog_grant_o,
   input wire logic mem_wr_o,
   input wire logic mem_space_o,
   input wire logic mem_erase_o,
   input wire logic cpu_stall_o
);
   logic wr_c;
   logic go_c;
   logic ok_c;
   logic fl_c;
   logic perm_q;
   logic [1:0] key_q;
   logic [7:0] alo_q;
   logic [6:0] ref_q;
   int unsigned pw_q;
   assign wr_c = psel_i & penable_i & pwrite_i;
   assign go_c = wr_c && paddr_i == `NVSW_OFF_CONTROL && pwdata_i[`NVSW_BIT_GO];
   assign ok_c = key_q == 2'h2 && perm_q;
   assign fl_c = go_c && ok_c && pwdata_i[`NVSW_BIT_SPACE];
   always_ff @(posedge sys_clk_i)
   begin
      if (power_on_i)
         pw_q <= 0;
      else if (pw_q < PWRT_CYCLES)
         pw_q <= pw_q + 1;
   end
   // key progress: 55h then aah with no other write between
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || power_on_i)
         key_q <= 2'h0;
      else if (wr_c)
         key_q <= paddr_i != `NVSW_OFF_UNLOCK ? 2'h0 : pwdata_i[7:0] == `NVSW_KEY_FIRST ? 2'h1 :
            (key_q == 2'h1 && pwdata_i[7:0] == `NVSW_KEY_SECOND) ? 2'h2 : 2'h0;
   end
   // permit bit as held before the go write; power-up or a control write with the permit bit low clears it
   always_ff @(posedge sys_clk_i)
   begin
      if (power_on_i)
         perm_q <= 1'b0;
      else if (wr_c && paddr_i == `NVSW_OFF_CONTROL)
         perm_q <= pwdata_i[`NVSW_BIT_PERMIT];
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (wr_c && paddr_i == `NVSW_OFF_ADDR_LO)
         alo_q <= pwdata_i[7:0];
   end
   // quiet window after a refused start
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || power_on_i)
         ref_q <= 7'h0;
      else if (go_c && !(ok_c && (pwdata_i[`NVSW_BIT_SPACE] || pw_q >= PWRT_CYCLES)))
         ref_q <= 7'h3c;
      else if (ref_q != 7'h0)
         ref_q <= ref_q - 7'h1;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i || power_on_i);
   sequence ee_start_s;
      go_c && ok_c && !pwdata_i[`NVSW_BIT_SPACE] && pw_q >= PWRT_CYCLES;
   endsequence
   sequence erase_s;
      mem_erase_o [*8];
   endsequence
   chk_ee_write_time: assert property (ee_start_s |-> ##[50:54] mem_wr_o)
      else $error("eeprom write missing after accepted start");
   chk_refused_quiet: assert property (ref_q != 7'h0 |-> !mem_wr_o && !cpu_stall_o)
      else $error("refused start reached the array");
   chk_pwrt_block: assert property (mem_wr_o && !mem_space_o |-> pw_q >= PWRT_CYCLES)
      else $error("eeprom write while power-up timer runs");
   chk_flash_stall: assert property (fl_c |-> ##[1:2] cpu_stall_o)
      else $error("no stall after flash word start");
   chk_word_quick: assert property (fl_c && alo_q[2:0] != 3'h7 |-> ##[2:6] !cpu_stall_o)
      else $error("buffered word stall too long");
   chk_erase_after_last: assert property (fl_c && alo_q[2:0] == 3'h7 |-> ##[1:6] erase_s)
      else $error("no erase after last word");
   chk_erase_stall: assert property (mem_erase_o |-> cpu_stall_o)
      else $error("erase without stall");
   chk_ee_wr_pulse: assert property ($rose(mem_wr_o) && !mem_space_o |=> !mem_wr_o)
      else $error("eeprom write strobe longer than one cycle");
   chk_grant_fuse: assert property (ext_prog_grant_o == (ext_prog_req_i && data_lock_fuse_i))
      else $error("external grant ignores lock fuse");
endmodule
bind nvsw_ctrl nvsw_ctrl_asserts #(.PWRT_CYCLES(PWRT_CYCLES)) i_nvsw_ctrl_asserts (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .power_on_i(power_on_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .data_lock_fuse_i(data_lock_fuse_i), .ext_prog_req_i(ext_prog_req_i),
   .ext_prog_grant_o(ext_prog_grant_o), .mem_wr_o(mem_wr_o), .mem_space_o(mem_space_o),
   .mem_erase_o(mem_erase_o), .cpu_stall_o(cpu_stall_o));

// ---- testbench/nvsw_ctrl_test.sv ----
// self-checking bench for the nvm self-write controller
`timescale 1ns/1ns
`include "nvsw_defs.svh"
`define CK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module nvsw_ctrl_test;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic power_on_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0;
   logic data_lock_fuse_i = 1'b1;
   logic ext_prog_req_i = 1'b0;
   logic [31:0] prdata_o;
   logic pready_o, ext_prog_grant_o, mem_wr_o, mem_erase_o, cpu_stall_o, irq_o;
   logic [31:0] v;
   logic pslverr_o, mem_rd_o, mem_space_o;
   logic [12:0] mem_addr_o, wa, ra;
   logic [13:0] mem_wdata_o, wd;
   logic [13:0] mem_rdata_i = 14'h1234;
   int nfl = 0;
   int nbad = 0;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int nwr = 0;
   int nst = 0;
   int ner = 0;
   int s;
   always #50 sys_clk_i = ~sys_clk_i;
   nvsw_ctrl #(.PWRT_CYCLES(20), .ERASE_CYCLES(16)) i_nvsw_ctrl (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .power_on_i(power_on_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .data_lock_fuse_i(data_lock_fuse_i), .ext_prog_req_i(ext_prog_req_i),
      .ext_prog_grant_o(ext_prog_grant_o), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o),
      .mem_space_o(mem_space_o), .mem_erase_o(mem_erase_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .cpu_stall_o(cpu_stall_o),
      .irq_o(irq_o));
   // array activity counted on the falling edge, away from bench reads
   always @(negedge sys_clk_i)
   begin
      nwr += (mem_wr_o === 1'b1);
      nst += (cpu_stall_o === 1'b1);
      ner += (mem_erase_o === 1'b1);
      if (mem_wr_o === 1'b1)
      begin
         wa = mem_addr_o;
         wd = mem_wdata_o;
         // flash block 08h..0fh, each word data_hi[5:0]:data_lo
         if (mem_space_o === 1'b1)
         begin
            nbad += (mem_addr_o !== 13'h008 + 13'(nfl) || mem_wdata_o !== 14'h2a3c);
            nfl++;
         end
      end
      if (mem_rd_o === 1'b1)
         ra = mem_addr_o;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      v = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task automatic go(input logic [7:0] k1, input logic [7:0] k2, input logic [31:0] c);
      apb(1'b1, `NVSW_OFF_CONTROL, c & ~(32'h1 << `NVSW_BIT_GO));
      apb(1'b1, `NVSW_OFF_UNLOCK, {24'h0, k1});
      apb(1'b1, `NVSW_OFF_UNLOCK, {24'h0, k2});
      apb(1'b1, `NVSW_OFF_CONTROL, c);
   endtask
   task automatic refused(input string n);
      repeat (60) @(posedge sys_clk_i);
      apb(1'b0, `NVSW_OFF_IRQ_FLAGS, 32'h0);
      `CK(n, 1'b0, v[`NVSW_BIT_DONE])
      `CK(n, 0, nwr)
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      power_on_i <= 1'b0;
      @(posedge sys_clk_i);
      apb(1'b0, `NVSW_OFF_CONTROL, 32'h0);
      `CK("permit at power-up", 1'b0, v[`NVSW_BIT_PERMIT])
      go(8'h55, 8'haa, 32'h06);
      refused("start in power-up time");
      apb(1'b1, `NVSW_OFF_CORE_IRQ, 32'h80);
      apb(1'b1, `NVSW_OFF_IRQ_EN, 32'h10);
      go(8'haa, 8'h55, 32'h06);
      refused("keys reversed");
      go(8'h55, 8'haa, 32'h02);
      refused("go without permit");
      apb(1'b1, `NVSW_OFF_DATA_LO, 32'h3c);
      apb(1'b1, `NVSW_OFF_ADDR_LO, 32'h5a);
      go(8'h55, 8'haa, 32'h06);
      apb(1'b1, `NVSW_OFF_CONTROL, 32'h0);
      for (int k = 0; k < 100 && irq_o !== 1'b1; k++) @(posedge sys_clk_i);
      `CK("done irq", 1'b1, irq_o)
      `CK("one eeprom write", 1, nwr)
      `CK("eeprom address", 13'h05a, wa)
      `CK("eeprom data", 14'h03c, wd)
      apb(1'b0, `NVSW_OFF_CONTROL, 32'h0);
      `CK("go cleared", 1'b0, v[`NVSW_BIT_GO])
      apb(1'b1, `NVSW_OFF_IRQ_EN, 32'h0);
      `CK("irq masked", 1'b0, irq_o)
      apb(1'b1, `NVSW_OFF_IRQ_EN, 32'h10);
      `CK("irq unmasked", 1'b1, irq_o)
      apb(1'b1, `NVSW_OFF_IRQ_CLEAR, 32'h10);
      `CK("irq cleared", 1'b0, irq_o)
      apb(1'b1, `NVSW_OFF_ADDR_HI, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, `NVSW_OFF_ADDR_LO, 32'h08 + i);
         apb(1'b1, `NVSW_OFF_DATA_HI, 32'h2a);
         s = nst;
         go(8'h55, 8'haa, 32'h86);
         for (int k = 0; k < 100 && cpu_stall_o !== 1'b0; k++) @(posedge sys_clk_i);
         `CK("stall", 1'b1, i < 7 ? nst - s < 6 : nst - s >= 16)
      end
      `CK("erase cycles", 1'b1, ner >= 16)
      `CK("flash words", 8, nfl)
      `CK("flash order", 0, nbad)
      apb(1'b1, `NVSW_OFF_CONTROL, 32'h81);
      apb(1'b0, `NVSW_OFF_DATA_LO, 32'h0);
      `CK("read low byte", 32'h34, v)
      apb(1'b0, `NVSW_OFF_DATA_HI, 32'h0);
      `CK("read high part", 32'h12, v)
      `CK("read address", 13'h00f, ra)
      go(8'h55, 8'haa, 32'h06);
      repeat (5) @(posedge sys_clk_i);
      reset_i <= 1'b1;
      @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(posedge sys_clk_i);
      apb(1'b0, `NVSW_OFF_CONTROL, 32'h0);
      `CK("fault after reset", 1'b1, v[`NVSW_BIT_FAULT])
      apb(1'b0, 12'h0fc, 32'hffffffff);
      `CK("unmapped read", 32'h0, v)
      `CK("slave error", 1'b0, pslverr_o)
      for (int f = 0; f < 4; f++)
      begin
         data_lock_fuse_i <= f[0];
         ext_prog_req_i <= f[1];
         @(posedge sys_clk_i);
         `CK("external grant", f[0] & f[1], ext_prog_grant_o)
      end
      tally_and_finish();
   end
endmodule
